// ---- rtl/tac_map.svh ----
`ifndef TAC_MAP_SVH
`define TAC_MAP_SVH
// ==========================================
// Register byte offsets on the APB side
`define TAC_OFS_CNT_LO 8'h00
`define TAC_OFS_CNT_HI 8'h04
`define TAC_OFS_RLD_LO 8'h08
`define TAC_OFS_RLD_HI 8'h0C
`define TAC_OFS_CTRL 8'h10
`define TAC_OFS_STAT 8'h14
// ==========================================
// Control register fields
`define TAC_CTRL_MODE_HI 7
`define TAC_CTRL_MODE_LO 5
`define TAC_CTRL_CAPT 6
`define TAC_CTRL_POL 5
`define TAC_CTRL_RUN 4
// ==========================================
// Status register fields
`define TAC_STAT_PEND 0
`define TAC_STAT_GIE 1
`define TAC_STAT_TIE 2
`define TAC_STAT_PIN 3
// ==========================================
// Reset values
`define TAC_RST_CTRL 8'h00
`define TAC_RST_CNT 16'h0000
`define TAC_RST_RLD 16'h0000
// ==========================================
// Pin synchroniser depth
`define TAC_SYNC_STAGES 2
`endif

// ---- rtl/tac_pkg.sv ----
// ==========================================
// Types shared by the timer files
package tac_pkg;
    // Mode codes held in control bits 7..5
    typedef enum logic [2:0] {
        TAC_EXT_POS = 3'h0,
        TAC_EXT_NEG = 3'h1,
        TAC_BAD_2 = 3'h2,
        TAC_BAD_3 = 3'h3,
        TAC_RELOAD = 3'h4,
        TAC_RELOAD_TGL = 3'h5,
        TAC_CAPT_POS = 3'h6,
        TAC_CAPT_NEG = 3'h7
    } tac_mode_t;
endpackage

// ---- rtl/tac_sync.sv ----
`timescale 1ns/10ps
// ==========================================
// Two-stage level synchroniser
module tac_sync #(
    parameter int STAGES = 2
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    // Shift chain; only the last stage is read outside
    logic [STAGES-1:0] chain_reg;

    // Elaboration guard: fewer than two stages is not a synchroniser
    if (STAGES < 2) begin : g_chk
        $error("tac_sync needs at least two stages");
    end

    // Sample the pin, then pass it down the chain
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            chain_reg <= '0;
        end else begin
            chain_reg <= {chain_reg[STAGES-2:0], async_in};
        end
    end

    assign sync_out = chain_reg[STAGES-1];
endmodule

// ---- rtl/tac_timer.sv ----
`timescale 1ns/10ps
`include "tac_map.svh"
// Overview of operation
// - Reload mode: decrement each cycle while running
// - Underflow loads reload value, keeps counting
// - Mode 101 drives pin, toggles each underflow
// - Mode 100 reloads silently; underflow raises interrupt
// - External mode counts selected pin edges
// - Codes 000/001 pick rising/falling count edge
// - External underflow reloads and raises interrupt
// - Capture mode counts; edge copies count
// - Code 110 rising, 111 falling capture edge
// - Capture edge raises interrupt, not underflow
// - Run bit starts; clearing holds the count
// - Pulse: on time counted, off time reloaded
// - Counter and reload reg as byte pairs
// - Acknowledge clears global enable; pending stays
module tac_timer #(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_io_in,
    output logic timer_io_out,
    output logic timer_io_oe,
    input wire logic irq_ack,
    output logic timer_irq
);
    // ==========================================
    // Elaboration check
    // The register map splits the count into exactly two bytes
    if (CNT_W != 16) begin : g_chk
        $error("tac_timer supports a 16-bit counter only");
    end

    // ==========================================
    // State
    logic [CNT_W-1:0] down_counter_reg; // Running count
    logic [CNT_W-1:0] reload_capture_reg; // Reload or capture value
    logic [7:0] timer_serial_control_reg; // Mode, run, spare bits
    logic pend_reg; // Sticky timer pending flag
    logic global_irq_enable_reg; // Global enable
    logic tie_reg; // Timer interrupt enable
    logic pin_reg; // Level driven on the pin
    logic oe_reg; // Pin drive enable
    logic irq_reg; // Interrupt request out
    logic [31:0] prdata_reg; // Read data, loaded in setup
    logic pready_reg; // One access cycle per transfer
    logic pslverr_reg; // Unmapped address answer
    logic pin_d_reg; // Previous synchronised pin

    // ==========================================
    // Decode of the control register
    tac_pkg::tac_mode_t mode;
    logic run; // Run bit
    logic ext_mode; // Codes 000 and 001
    logic tmr_mode; // Codes 100 and 101
    logic cap_mode; // Codes 110 and 111
    logic pin_s; // Synchronised pin level
    logic rise; // Rising edge seen this cycle
    logic fall; // Falling edge seen this cycle
    logic sel_edge; // Edge chosen by polarity bit
    logic step; // Counter moves this cycle
    logic uflow; // Count leaves zero
    logic capt; // Capture strobe
    logic hit; // Interrupt source event

    assign mode = tac_pkg::tac_mode_t'(
        timer_serial_control_reg[`TAC_CTRL_MODE_HI:`TAC_CTRL_MODE_LO]);
    assign run = timer_serial_control_reg[`TAC_CTRL_RUN];
    // Codes 010 and 011 leave all three clear: the timer idles
    assign ext_mode = (mode == tac_pkg::TAC_EXT_POS) || (mode == tac_pkg::TAC_EXT_NEG);
    assign tmr_mode = (mode == tac_pkg::TAC_RELOAD) || (mode == tac_pkg::TAC_RELOAD_TGL);
    assign cap_mode = (mode == tac_pkg::TAC_CAPT_POS) || (mode == tac_pkg::TAC_CAPT_NEG);

    // ==========================================
    // Pin synchroniser and edge detection
    // The pin is asynchronous; two flops guard against metastability
    tac_sync #(
        .STAGES(`TAC_SYNC_STAGES)
    ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(timer_io_in),
        .sync_out(pin_s)
    );

    // Third flop gives the previous level for edge detection
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_d_reg <= 1'b0;
        end else begin
            pin_d_reg <= pin_s;
        end
    end

    // One-cycle edge pulses, so each edge counts once
    assign rise = pin_s & ~pin_d_reg;
    assign fall = ~pin_s & pin_d_reg;
    // Polarity bit: 0 rising, 1 falling, in both edge modes
    assign sel_edge = timer_serial_control_reg[`TAC_CTRL_POL] ? fall : rise;

    // ==========================================
    // Count enable, underflow and capture
    // Cycle rate in timer and capture modes, pin edges in external mode
    assign step = run & ((ext_mode & sel_edge) | tmr_mode | cap_mode);
    // Capture mode simply wraps; it has no reload source
    assign uflow = step & ~cap_mode & (down_counter_reg == '0);
    assign capt = run & cap_mode & sel_edge;
    // Capture edge replaces underflow as the interrupt source
    assign hit = cap_mode ? capt : uflow;

    // ==========================================
    // APB strobes
    logic setup; // Setup cycle of a transfer
    logic wr; // Write takes effect this edge
    logic mapped; // Address hits a register

    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & pready_reg & ~pslverr_reg;
    always_comb begin
        case (paddr)
            `TAC_OFS_CNT_LO, `TAC_OFS_CNT_HI, `TAC_OFS_RLD_LO,
            `TAC_OFS_RLD_HI, `TAC_OFS_CTRL, `TAC_OFS_STAT: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Ready one cycle after setup: every transfer has one access cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~mapped;
        end
    end

    // Read data is sampled in setup; a count moving meanwhile is one cycle stale
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup & ~pwrite) begin
            case (paddr)
                // Byte-wide views of the counter and reload pair
                `TAC_OFS_CNT_LO: begin
                    prdata_reg <= {24'h00_0000, down_counter_reg[7:0]};
                end
                `TAC_OFS_CNT_HI: begin
                    prdata_reg <= {24'h00_0000, down_counter_reg[15:8]};
                end
                `TAC_OFS_RLD_LO: begin
                    prdata_reg <= {24'h00_0000, reload_capture_reg[7:0]};
                end
                `TAC_OFS_RLD_HI: begin
                    prdata_reg <= {24'h00_0000, reload_capture_reg[15:8]};
                end
                `TAC_OFS_CTRL: begin
                    prdata_reg <= {24'h00_0000, timer_serial_control_reg};
                end
                `TAC_OFS_STAT: begin
                    prdata_reg <= {28'h000_0000, pin_reg, tie_reg, global_irq_enable_reg, pend_reg};
                end
                // Unmapped reads return zero with an error
                default: begin
                    prdata_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ==========================================
    // Control register
    // Bits 3..0 are plain storage for the neighbouring serial port
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            timer_serial_control_reg <= `TAC_RST_CTRL;
        end else if (wr && paddr == `TAC_OFS_CTRL) begin
            timer_serial_control_reg <= pwdata[7:0];
        end
    end

    // ==========================================
    // Down counter
    // A software write wins over counting in the same cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            down_counter_reg <= `TAC_RST_CNT;
        end else if (wr && paddr == `TAC_OFS_CNT_LO) begin
            down_counter_reg[7:0] <= pwdata[7:0];
        end else if (wr && paddr == `TAC_OFS_CNT_HI) begin
            down_counter_reg[15:8] <= pwdata[7:0];
        end else if (uflow) begin
            // Reload replaces zero; no all-ones state in between
            down_counter_reg <= reload_capture_reg;
        end else if (step) begin
            down_counter_reg <= down_counter_reg - 1'b1;
        end
    end

    // ==========================================
    // Reload and capture register
    // A capture wins over a software write in the same cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reload_capture_reg <= `TAC_RST_RLD;
        end else if (capt) begin
            reload_capture_reg <= down_counter_reg;
        end else if (wr && paddr == `TAC_OFS_RLD_LO) begin
            reload_capture_reg[7:0] <= pwdata[7:0];
        end else if (wr && paddr == `TAC_OFS_RLD_HI) begin
            reload_capture_reg[15:8] <= pwdata[7:0];
        end
    end

    // ==========================================
    // Timer pin
    // Software presets the level, e.g. high for the on phase
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_reg <= 1'b0;
        end else if (uflow && mode == tac_pkg::TAC_RELOAD_TGL) begin
            pin_reg <= ~pin_reg;
        end else if (wr && paddr == `TAC_OFS_STAT) begin
            pin_reg <= pwdata[`TAC_STAT_PIN];
        end
    end

    // Only the toggle mode drives the pin; other modes leave it an input
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= (mode == tac_pkg::TAC_RELOAD_TGL);
        end
    end

    // ==========================================
    // Interrupt flags
    // Pending is write-one-to-clear; a new event beats the clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pend_reg <= 1'b0;
        end else if (hit) begin
            pend_reg <= 1'b1;
        end else if (wr && paddr == `TAC_OFS_STAT && pwdata[`TAC_STAT_PEND]) begin
            pend_reg <= 1'b0;
        end
    end

    // Acknowledge drops the global enable; software sets it again
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            global_irq_enable_reg <= 1'b0;
        end else if (irq_ack) begin
            global_irq_enable_reg <= 1'b0;
        end else if (wr && paddr == `TAC_OFS_STAT) begin
            global_irq_enable_reg <= pwdata[`TAC_STAT_GIE];
        end
    end

    // Timer interrupt enable
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tie_reg <= 1'b0;
        end else if (wr && paddr == `TAC_OFS_STAT) begin
            tie_reg <= pwdata[`TAC_STAT_TIE];
        end
    end

    // Request level follows the flags one cycle later
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= global_irq_enable_reg & tie_reg & pend_reg & ~irq_ack;
        end
    end

    // ==========================================
    // Outputs, all straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign timer_io_out = pin_reg;
    assign timer_io_oe = oe_reg;
    assign timer_irq = irq_reg;

    // ==========================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Count steps that neither write nor reload
    logic plain_step;
    assign plain_step = step & ~uflow & ~(wr & (paddr == `TAC_OFS_CNT_LO || paddr == `TAC_OFS_CNT_HI));

    sequence s_uflow;
        uflow && !(wr && (paddr == `TAC_OFS_CNT_LO || paddr == `TAC_OFS_CNT_HI));
    endsequence

    count_dec_a: assert property (
        plain_step |=> down_counter_reg == $past(down_counter_reg) - 16'h0001)
        else $error("count did not decrement");

    reload_take_a: assert property (
        s_uflow |=> down_counter_reg == $past(reload_capture_reg))
        else $error("underflow did not reload");

    pin_toggle_a: assert property (
        uflow && mode == tac_pkg::TAC_RELOAD_TGL |=> pin_reg != $past(pin_reg))
        else $error("pin did not toggle");

    drive_mode_a: assert property (
        timer_io_oe |-> $past(mode) == tac_pkg::TAC_RELOAD_TGL)
        else $error("pin driven outside toggle mode");

    ext_hold_a: assert property (
        run && ext_mode && !sel_edge && !wr |=> $stable(down_counter_reg))
        else $error("external counter moved without edge");

    capture_copy_a: assert property (
        capt |=> reload_capture_reg == $past(down_counter_reg))
        else $error("capture missed");

    capt_pend_a: assert property (
        capt |=> pend_reg)
        else $error("capture did not set pending");

    stop_hold_a: assert property (
        !run && !wr |=> $stable(down_counter_reg))
        else $error("stopped timer moved");

    ack_clear_a: assert property (
        irq_ack |=> !global_irq_enable_reg ##1 !timer_irq)
        else $error("acknowledge did not clear enable");

    bus_answer_a: assert property (
        setup |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
endmodule

// ---- bench/tac_pin_src.sv ----
`timescale 1ns/10ps
// ==========================================
// Far side of the timer pin: an edge source that yields to the device
module tac_pin_src (
    input wire logic mclk,
    input wire logic flip,
    input wire logic drv_oe,
    input wire logic drv_level,
    output logic pin
);
    // Level the outside source would put on the pin
    logic src_reg = 1'b0;

    // One level change for each request pulse
    always_ff @(posedge mclk) begin
        if (flip) begin
            src_reg <= ~src_reg;
        end
    end

    // Device drive wins, so the source acts as a load while toggling
    assign pin = drv_oe ? drv_level : src_reg;
endmodule

// ---- bench/timer_autoload_capture_tb.sv ----
`timescale 1ns/10ps
`include "tac_map.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module timer_autoload_capture_tb;
    // ==========================================
    // Clock, bus and pin signals
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, pin, io_out, io_oe, irq_ack = 1'b0, timer_irq, flip = 1'b0;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic [31:0] r;
    int n_errors = 0;
    int n_compared = 0;

    always #12.5 mclk = ~mclk;

    tac_timer #(.CNT_W(16)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_io_in(pin), .timer_io_out(io_out), .timer_io_oe(io_oe),
        .irq_ack(irq_ack), .timer_irq(timer_irq));
    tac_pin_src i_src (.mclk(mclk), .flip(flip), .drv_oe(io_oe), .drv_level(io_out), .pin(pin));

    // ==========================================
    // Verdict, reached from the main flow and from any exhausted wait
    task automatic stop_test();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================
    // APB master: setup, then access held until pready is seen
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_errors++;
            stop_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never reassigns psel in this time step
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    // Reads only note the expectation; the monitor below judges it
    task automatic rd(input logic [7:0] a, input logic [32:0] ex);
        exp_q.push_back(ex);
        xfer(1'b0, a, 8'h00);
    endtask
    // Run for n idle cycles between the start and stop writes: n+3 steps
    task automatic run_for(input logic [7:0] m, input int n);
        wr(`TAC_OFS_CTRL, m | 8'h10);
        repeat (n) @(posedge mclk);
        wr(`TAC_OFS_CTRL, m);
    endtask
    // One pin level change, then time for the synchroniser to settle
    task automatic pin_flip();
        flip <= 1'b1;
        @(posedge mclk);
        flip <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
    task automatic set16(input logic [7:0] lo_a, input logic [15:0] v);
        wr(lo_a, v[7:0]);
        wr(lo_a + 8'h04, v[15:8]);
    endtask

    // ==========================================
    // Read monitor: oldest note against {pslverr, prdata}
    always @(posedge mclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("unexpected at %0t: got %h expected %h", $time, prdata, 33'h0);
            end else begin
                e = exp_q.pop_front();
                `CHK({pslverr, prdata}, e)
            end
        end
    end

    // ==========================================
    // Main sequence; mode codes 010 and 011 are never written
    initial begin
        void'($urandom(53957));
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 6; a++) rd(8'(a * 4), 33'h0);
        rd(8'h18, {1'b1, 32'h0});
        wr(8'h18, 8'hFF);
        // Random byte pairs for count and reload, timer stopped
        repeat (4) begin
            r = $urandom;
            set16(`TAC_OFS_RLD_LO, r[15:0]);
            set16(`TAC_OFS_CNT_LO, r[31:16]);
            rd(`TAC_OFS_RLD_LO, {25'h0, r[7:0]});
            rd(`TAC_OFS_RLD_HI, {25'h0, r[15:8]});
            rd(`TAC_OFS_CNT_LO, {25'h0, r[23:16]});
            rd(`TAC_OFS_CNT_HI, {25'h0, r[31:24]});
        end
        // Plain reload: 3,2,1,0,10,9,8 then hold
        wr(`TAC_OFS_CTRL, 8'h80);
        wr(`TAC_OFS_STAT, 8'h07);
        set16(`TAC_OFS_CNT_LO, 16'h0003);
        set16(`TAC_OFS_RLD_LO, 16'h000A);
        run_for(8'h80, 3);
        repeat (4) @(posedge mclk);
        rd(`TAC_OFS_CNT_LO, 33'h8);
        rd(`TAC_OFS_CNT_HI, 33'h0);
        rd(`TAC_OFS_STAT, 33'h7);
        `CHK(timer_irq, 1'b1)
        `CHK(io_oe, 1'b0)
        irq_ack <= 1'b1;
        @(posedge mclk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK(timer_irq, 1'b0)
        rd(`TAC_OFS_STAT, 33'h5);
        wr(`TAC_OFS_STAT, 8'h05);
        rd(`TAC_OFS_STAT, 33'h4);
        // Toggle mode, pin starts high: 1,0,2,1,0 gives one toggle
        wr(`TAC_OFS_STAT, 8'h09);
        set16(`TAC_OFS_CNT_LO, 16'h0001);
        set16(`TAC_OFS_RLD_LO, 16'h0002);
        wr(`TAC_OFS_CTRL, 8'hA0);
        @(posedge mclk);
        `CHK({io_oe, io_out}, 2'b11)
        run_for(8'hA0, 1);
        @(posedge mclk);
        `CHK({io_oe, io_out}, 2'b10)
        rd(`TAC_OFS_CNT_LO, 33'h0);
        rd(`TAC_OFS_RLD_LO, 33'h2);
        wr(`TAC_OFS_CTRL, 8'h00);
        // External count: three rising and two falling edges
        for (int m = 0; m < 2; m++) begin
            wr(`TAC_OFS_STAT, 8'h01);
            set16(`TAC_OFS_CNT_LO, 16'h0002);
            set16(`TAC_OFS_RLD_LO, 16'h0007);
            wr(`TAC_OFS_CTRL, 8'(m << 5) | 8'h10);
            repeat (5) pin_flip();
            wr(`TAC_OFS_CTRL, 8'(m << 5));
            pin_flip();
            rd(`TAC_OFS_CNT_LO, (m == 0) ? 33'h7 : 33'h0);
            rd(`TAC_OFS_STAT, (m == 0) ? 33'h1 : 33'h0);
        end
        // Capture: rising then falling edge while counting from 0x1000
        for (int m = 6; m < 8; m++) begin
            wr(`TAC_OFS_CTRL, 8'(m << 5));
            wr(`TAC_OFS_STAT, 8'h01);
            set16(`TAC_OFS_RLD_LO, 16'h5555);
            set16(`TAC_OFS_CNT_LO, 16'h1000);
            wr(`TAC_OFS_CTRL, 8'(m << 5) | 8'h10);
            pin_flip();
            rd(`TAC_OFS_STAT, (m == 6) ? 33'h1 : 33'h0);
            rd(`TAC_OFS_RLD_HI, (m == 6) ? 33'h0F : 33'h55);
            pin_flip();
            rd(`TAC_OFS_STAT, 33'h1);
            rd(`TAC_OFS_RLD_HI, 33'h0F);
            wr(`TAC_OFS_CTRL, 8'h00);
        end
        repeat (2) @(posedge mclk);
        if (exp_q.size() != 0) n_errors++;
        stop_test();
    end
endmodule
